// *** design/ecsr_pkg.sv ***
// Package with register offsets, field positions and timing constants.
package ecsr_pkg;
    localparam logic [3:0] ADDR_MAIN_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_TX_STATUS = 4'h1;
    localparam logic [3:0] ADDR_DEV_STATUS = 4'h2;
    localparam logic [3:0] ADDR_SCRATCH = 4'h3;
    localparam logic [3:0] ADDR_CHECKSUM = 4'h4;
    localparam logic [3:0] ADDR_COLL_SETTINGS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;
    // Main control bit positions.
    localparam int BIT_RX_EN = 0;
    localparam int BIT_TX_REQ = 1;
    localparam int BIT_CS_SKIP = 2;
    localparam int BIT_CS_SEED = 3;
    localparam int BIT_DMA_COPY = 4;
    localparam int BIT_DMA_GO = 5;
    localparam int BIT_PKT_DEC = 8;
    // Transmit status bit positions.
    localparam int BIT_FCS_BAD = 4;
    localparam int BIT_DEFER = 7;
    localparam int BIT_LONG_WAIT = 8;
    localparam int BIT_COLL_LIMIT = 9;
    localparam int BIT_LATE_COLL = 10;
    // Global status bit positions and the global interrupt enable bit.
    localparam int BIT_IRQ_PEND = 15;
    localparam int BIT_PAUSE_IDLE = 14;
    localparam int BIT_RX_ACTIVE = 13;
    localparam int BIT_CLK_STABLE = 12;
    localparam int BIT_PHY_FULL = 10;
    localparam int BIT_PHY_LINK = 8;
    localparam int BIT_GLOBAL_IRQ_EN = 15;
    // Mask of writable control bits and all-zero and all-one words.
    localparam logic [15:0] CTRL_WR_MASK = 16'h003f;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONES16 = 16'hffff;
    localparam logic [7:0] LATE_MARGIN = 8'h08;
    localparam logic [4:0] LIMIT_EXTRA = 5'h01;
    // Excessive defer: 24,288 bit times at 10 Mb/s is 2428.8 us.
    localparam real LONG_WAIT_NS = 2428800.0;
    localparam real CLK_PERIOD_NS = 20.0;
    localparam int LONG_WAIT_CYCLES = int'(LONG_WAIT_NS / CLK_PERIOD_NS);
endpackage

// *** design/ecsr_regs.sv ***
// Control and status registers of the Ethernet controller core.
//
// Contract
// - Writing DMA go starts DMA; bit reads one while busy, cleared on done.
// - Copy select one writes DMA data to destination; zero ignores it.
// - Seed select one seeds checksum with complement of register, else zero.
// - Checksum skip keeps checksum register; otherwise result written at end.
// - Transmit request sends one frame, stays set until transmit done.
// - Receive enable stores passing packets; cleared means all are ignored.
// - Collision past window plus 8 bytes aborts and sets late collision.
// - Collisions reaching limit plus one abort and set collision limit bit.
// - Medium busy over 24,288 bit times aborts and sets long wait.
// - Defer bit set on temporary postponement, zero if none or excessive.
// - FCS mismatch bit set when supplied FCS differed from computed CRC.
// - Four-bit field reports collisions of the last packet.
// - Collision and defer indications only apply in half duplex.
// - Pending bit when flag and enable; pin low if global enable too.
// - Report pause machine idle; host changes pause settings only then.
// - Receive active reads one while a packet is being taken in.
// - Clocks stable reads zero until clocks run; host limits accesses.
// - Read-only bit gives PHY duplex, one for full.
// - Read-only bit gives link state, one when linked.
// - Eight-bit count of stored packets awaiting software.
// - Decrement bit self-clears so decrements can run back to back.
//
// The implementer's own choices: the strobed register port and the register addresses.
module ecsr_regs #(
    parameter int LONG_WAIT_LIMIT = ecsr_pkg::LONG_WAIT_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic dma_done_in,
    input wire logic [15:0] dma_sum_in,
    input wire logic tx_done_in,
    input wire logic tx_collision_in,
    input wire logic [7:0] tx_bytes_sent_in,
    input wire logic tx_medium_busy_in,
    input wire logic tx_fcs_bad_in,
    input wire logic rx_active_in,
    input wire logic rx_stored_in,
    input wire logic pause_idle_in,
    input wire logic clocks_stable_in,
    input wire logic phy_full_duplex_in,
    input wire logic phy_link_up_in,
    output logic dma_start_out,
    output logic dma_copy_out,
    output logic [15:0] dma_seed_out,
    output logic dma_sum_en_out,
    output logic tx_start_out,
    output logic tx_abort_out,
    output logic rx_accept_out,
    output logic irq_n_out
);
    logic [5:0] ctrl_reg, ctrl_next;
    logic [15:0] sum_reg, sum_next;
    logic [15:0] scratch_reg;
    logic [15:0] coll_set_reg;
    logic [15:0] irq_flag_reg, irq_flag_next;
    logic [15:0] irq_en_reg;
    logic late_reg, late_next;
    logic limit_reg, limit_next;
    logic long_reg, long_next;
    logic defer_reg, defer_next;
    logic fcs_reg, fcs_next;
    logic [3:0] tally_reg, tally_next;
    logic [4:0] cur_coll_reg, cur_coll_next;
    logic cur_defer_reg, cur_defer_next;
    logic [31:0] wait_reg, wait_next;
    logic [7:0] pkt_reg, pkt_next;
    logic [15:0] rdata_next;
    logic abort_reg, abort_next;
    logic start_dma_reg, start_tx_reg;

    // Decoded strobes and status words.
    wire logic wr_ctrl = wr_in && addr_in == ecsr_pkg::ADDR_MAIN_CONTROL;
    wire logic wr_sum = wr_in && addr_in == ecsr_pkg::ADDR_CHECKSUM;
    wire logic wr_flag = wr_in && addr_in == ecsr_pkg::ADDR_IRQ_FLAGS;
    wire logic half = !phy_full_duplex_in;
    wire logic tx_busy = ctrl_reg[ecsr_pkg::BIT_TX_REQ];
    wire logic coll = tx_busy && half && tx_collision_in;
    // Nine bits, so a large window cannot wrap into a false late hit.
    wire logic [8:0] late_lim =
        9'(coll_set_reg[15:8]) + 9'(ecsr_pkg::LATE_MARGIN);
    wire logic late_hit = coll && 9'(tx_bytes_sent_in) > late_lim;
    wire logic [4:0] coll_lim =
        5'(coll_set_reg[3:0]) + ecsr_pkg::LIMIT_EXTRA;
    wire logic limit_hit = coll && (cur_coll_reg + 5'h01) >= coll_lim;
    wire logic long_hit = tx_busy && half && tx_medium_busy_in
        && wait_reg >= 32'(LONG_WAIT_LIMIT);
    wire logic tx_end = tx_busy && (tx_done_in || late_hit
        || limit_hit || long_hit);
    wire logic irq_pend = |(irq_flag_reg & irq_en_reg);
    wire logic pkt_dec = wr_ctrl && wdata_in[ecsr_pkg::BIT_PKT_DEC];
    wire logic [15:0] tx_status = {5'h00, late_reg, limit_reg, long_reg,
        defer_reg, 2'h0, fcs_reg, tally_reg};
    wire logic [15:0] dev_status = {irq_pend, pause_idle_in, rx_active_in,
        clocks_stable_in, 1'b0, phy_full_duplex_in, 1'b0, phy_link_up_in,
        pkt_reg};
    wire logic [15:0] ctrl_view = {10'h000, ctrl_reg};

    // Control bits: software sets, hardware clears busy bits on completion.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = wdata_in[5:0] & ecsr_pkg::CTRL_WR_MASK[5:0];
            ctrl_next[ecsr_pkg::BIT_DMA_GO] = ctrl_reg[ecsr_pkg::BIT_DMA_GO]
                || wdata_in[ecsr_pkg::BIT_DMA_GO];
            ctrl_next[ecsr_pkg::BIT_TX_REQ] = ctrl_reg[ecsr_pkg::BIT_TX_REQ]
                || wdata_in[ecsr_pkg::BIT_TX_REQ];
        end
        if (ctrl_reg[ecsr_pkg::BIT_DMA_GO] && dma_done_in) begin
            ctrl_next[ecsr_pkg::BIT_DMA_GO] = 1'b0;
        end
        if (tx_end) begin
            ctrl_next[ecsr_pkg::BIT_TX_REQ] = 1'b0;
        end
    end

    // Checksum register: written by software or by the DMA result.
    always_comb begin
        sum_next = sum_reg;
        if (wr_sum) begin
            sum_next = wdata_in;
        end
        if (ctrl_reg[ecsr_pkg::BIT_DMA_GO] && dma_done_in
                && !ctrl_reg[ecsr_pkg::BIT_CS_SKIP]) begin
            sum_next = dma_sum_in;
        end
    end

    // Transmit attempt tracking; status is latched only at the end.
    always_comb begin
        cur_coll_next = cur_coll_reg;
        cur_defer_next = cur_defer_reg;
        wait_next = wait_reg;
        late_next = late_reg;
        limit_next = limit_reg;
        long_next = long_reg;
        defer_next = defer_reg;
        fcs_next = fcs_reg;
        tally_next = tally_reg;
        if (!tx_busy) begin
            cur_coll_next = 5'h00;
            cur_defer_next = 1'b0;
            wait_next = 32'h0;
        end else begin
            if (coll) begin
                cur_coll_next = cur_coll_reg + 5'h01;
            end
            if (half && tx_medium_busy_in) begin
                cur_defer_next = 1'b1;
                wait_next = wait_reg + 32'h1;
            end
        end
        if (tx_end) begin
            late_next = late_hit;
            limit_next = limit_hit && !late_hit;
            long_next = long_hit;
            defer_next = (cur_defer_reg || (half && tx_medium_busy_in))
                && !long_hit;
            fcs_next = tx_fcs_bad_in;
            tally_next = cur_coll_next[3:0];
        end
    end

    // Pending packet count; the decrement bit is never stored.
    always_comb begin
        pkt_next = pkt_reg;
        if (rx_stored_in && ctrl_reg[ecsr_pkg::BIT_RX_EN] && !pkt_dec
                && pkt_reg != 8'hff) begin
            pkt_next = pkt_reg + 8'h01;
        end else if (pkt_dec && !(rx_stored_in
                && ctrl_reg[ecsr_pkg::BIT_RX_EN]) && pkt_reg != 8'h00) begin
            pkt_next = pkt_reg - 8'h01;
        end
    end

    // Interrupt flags: software clears by writing ones; no event sets them.
    assign irq_flag_next = wr_flag ? (irq_flag_reg & ~wdata_in)
        : irq_flag_reg;

    // Read data selection.
    always_comb begin
        case (addr_in)
            ecsr_pkg::ADDR_MAIN_CONTROL: rdata_next = ctrl_view;
            ecsr_pkg::ADDR_TX_STATUS: rdata_next = tx_status;
            ecsr_pkg::ADDR_DEV_STATUS: rdata_next = dev_status;
            ecsr_pkg::ADDR_SCRATCH: rdata_next = scratch_reg;
            ecsr_pkg::ADDR_CHECKSUM: rdata_next = sum_reg;
            ecsr_pkg::ADDR_COLL_SETTINGS: rdata_next = coll_set_reg;
            ecsr_pkg::ADDR_IRQ_FLAGS: rdata_next = irq_flag_reg;
            ecsr_pkg::ADDR_IRQ_ENABLE: rdata_next = irq_en_reg;
            default: rdata_next = ecsr_pkg::ZERO16;
        endcase
    end

    assign abort_next = tx_end && (late_hit || limit_hit || long_hit);

    // State registers.
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= 6'h00;
            sum_reg <= ecsr_pkg::ZERO16;
            scratch_reg <= ecsr_pkg::ZERO16;
            coll_set_reg <= ecsr_pkg::ZERO16;
            irq_flag_reg <= ecsr_pkg::ZERO16;
            irq_en_reg <= ecsr_pkg::ZERO16;
            late_reg <= 1'b0;
            limit_reg <= 1'b0;
            long_reg <= 1'b0;
            defer_reg <= 1'b0;
            fcs_reg <= 1'b0;
            tally_reg <= 4'h0;
            cur_coll_reg <= 5'h00;
            cur_defer_reg <= 1'b0;
            wait_reg <= 32'h0;
            pkt_reg <= 8'h00;
            rdata_out <= ecsr_pkg::ZERO16;
            abort_reg <= 1'b0;
            start_dma_reg <= 1'b0;
            start_tx_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            sum_reg <= sum_next;
            if (wr_in && addr_in == ecsr_pkg::ADDR_SCRATCH) begin
                scratch_reg <= wdata_in;
            end
            if (wr_in && addr_in == ecsr_pkg::ADDR_COLL_SETTINGS) begin
                coll_set_reg <= wdata_in;
            end
            if (wr_in && addr_in == ecsr_pkg::ADDR_IRQ_ENABLE) begin
                irq_en_reg <= wdata_in;
            end
            irq_flag_reg <= irq_flag_next;
            late_reg <= late_next;
            limit_reg <= limit_next;
            long_reg <= long_next;
            defer_reg <= defer_next;
            fcs_reg <= fcs_next;
            tally_reg <= tally_next;
            cur_coll_reg <= cur_coll_next;
            cur_defer_reg <= cur_defer_next;
            wait_reg <= wait_next;
            pkt_reg <= pkt_next;
            rdata_out <= rd_in ? rdata_next : ecsr_pkg::ZERO16;
            abort_reg <= abort_next;
            start_dma_reg <= !ctrl_reg[ecsr_pkg::BIT_DMA_GO]
                && ctrl_next[ecsr_pkg::BIT_DMA_GO];
            start_tx_reg <= !ctrl_reg[ecsr_pkg::BIT_TX_REQ]
                && ctrl_next[ecsr_pkg::BIT_TX_REQ];
        end
    end

    // Outputs toward the DMA, transmit and receive engines and the interrupt pin, all registered.
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            dma_start_out <= 1'b0;
            dma_copy_out <= 1'b0;
            dma_seed_out <= ecsr_pkg::ZERO16;
            dma_sum_en_out <= 1'b0;
            tx_start_out <= 1'b0;
            tx_abort_out <= 1'b0;
            rx_accept_out <= 1'b0;
            irq_n_out <= 1'b1;
        end else begin
            dma_start_out <= start_dma_reg;
            dma_copy_out <= ctrl_reg[ecsr_pkg::BIT_DMA_COPY];
            dma_seed_out <= ctrl_reg[ecsr_pkg::BIT_CS_SEED]
                ? ~sum_reg : ecsr_pkg::ZERO16;
            dma_sum_en_out <= !ctrl_reg[ecsr_pkg::BIT_CS_SKIP];
            tx_start_out <= start_tx_reg;
            tx_abort_out <= abort_reg;
            rx_accept_out <= ctrl_reg[ecsr_pkg::BIT_RX_EN];
            irq_n_out <= !(irq_pend
                && irq_en_reg[ecsr_pkg::BIT_GLOBAL_IRQ_EN]);
        end
    end

    // Checks next to the logic they guard.
    sequence dma_go_s;
        wr_ctrl && wdata_in[ecsr_pkg::BIT_DMA_GO]
            && !ctrl_reg[ecsr_pkg::BIT_DMA_GO];
    endsequence
    dma_busy_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        dma_go_s |=> ctrl_reg[ecsr_pkg::BIT_DMA_GO]
        ##1 dma_start_out)
        else $error("DMA go did not stick or start");
    tx_clear_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        tx_end |=> !ctrl_reg[ecsr_pkg::BIT_TX_REQ])
        else $error("Transmit request not cleared at end");
    late_coll_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        late_hit |=> late_reg && !ctrl_reg[ecsr_pkg::BIT_TX_REQ])
        else $error("Late collision not reported");
    defer_excl_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in) !(defer_reg && long_reg))
        else $error("Defer and long wait both set");
    full_duplex_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        phy_full_duplex_in |-> !coll && !long_hit)
        else $error("Collision seen in full duplex");
    irq_pin_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (irq_pend && irq_en_reg[ecsr_pkg::BIT_GLOBAL_IRQ_EN]) |=> !irq_n_out)
        else $error("Interrupt pin not driven low");
    pkt_dec_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (pkt_dec && !rx_stored_in && pkt_reg != 8'h00)
        |=> pkt_reg == $past(pkt_reg) - 8'h01)
        else $error("Packet count did not decrement");
    pkt_inc_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (rx_stored_in && ctrl_reg[ecsr_pkg::BIT_RX_EN] && !pkt_dec
        && pkt_reg != 8'hff) |=> pkt_reg == $past(pkt_reg) + 8'h01)
        else $error("Packet count did not increment");
    rdata_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (rd_in && addr_in == ecsr_pkg::ADDR_DEV_STATUS)
        |=> rdata_out[7:0] == $past(pkt_reg))
        else $error("Status read shows wrong count");
endmodule

// *** tb/ecsr_core_model.sv ***
// Model of the DMA engine and transmit logic that sit behind the registers.
module ecsr_core_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic dma_start_in,
    input wire logic tx_start_in,
    input wire logic tx_abort_in,
    input wire logic [15:0] sum_val_in,
    input wire logic [3:0] coll_n_in,
    input wire logic [7:0] coll_bytes_in,
    input wire logic [7:0] busy_n_in,
    input wire logic fcs_bad_in,
    output logic dma_done_out,
    output logic [15:0] dma_sum_out,
    output logic tx_done_out,
    output logic tx_collision_out,
    output logic [7:0] tx_bytes_out,
    output logic tx_busy_out,
    output logic tx_fcs_bad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic aborted;

    // An abort ends the attempt, so no done pulse may follow it.
    always @(posedge clk_in) begin
        if (!reset_n_in || tx_start_in) begin
            aborted <= 1'b0;
        end else if (tx_abort_in) begin
            aborted <= 1'b1;
        end
    end

    // Answers each start; released buses show the inverse of the last value.
    initial begin
        dma_done_out = 1'b0;
        dma_sum_out = 16'h0000;
        tx_done_out = 1'b0;
        tx_collision_out = 1'b0;
        tx_bytes_out = 8'h00;
        tx_busy_out = 1'b0;
        tx_fcs_bad_out = 1'b0;
        forever begin
            @(posedge clk_in);
            if (dma_start_in) begin
                repeat (6) @(posedge clk_in);
                dma_sum_out <= sum_val_in;
                dma_done_out <= 1'b1;
                @(posedge clk_in);
                dma_done_out <= 1'b0;
                dma_sum_out <= ~sum_val_in;
            end else if (tx_start_in) begin
                @(posedge clk_in);
                for (int i = 0; i < busy_n_in && !aborted; i++) begin
                    tx_busy_out <= 1'b1;
                    @(posedge clk_in);
                end
                tx_busy_out <= 1'b0;
                for (int i = 0; i < coll_n_in && !aborted; i++) begin
                    tx_collision_out <= 1'b1;
                    tx_bytes_out <= coll_bytes_in;
                    @(posedge clk_in);
                    tx_collision_out <= 1'b0;
                    tx_bytes_out <= ~coll_bytes_in;
                    repeat (4) @(posedge clk_in);
                end
                if (!aborted) begin
                    tx_fcs_bad_out <= fcs_bad_in;
                    tx_done_out <= 1'b1;
                    @(posedge clk_in);
                    tx_done_out <= 1'b0;
                    tx_fcs_bad_out <= 1'b0;
                end
            end
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking testbench for the control and status registers.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, reset_n_in, wr_in, rd_in, rx_active_in, rx_stored_in;
    logic pause_idle_in, clocks_stable_in, phy_full_duplex_in, phy_link_up_in;
    logic [3:0] addr_in, coll_n;
    logic [15:0] wdata_in, rdata_out, dma_sum_in, dma_seed_out, sum_val, rd_val;
    logic dma_done_in, tx_done_in, tx_collision_in, tx_medium_busy_in;
    logic tx_fcs_bad_in, dma_start_out, dma_copy_out, dma_sum_en_out, fcs_bad;
    logic tx_start_out, tx_abort_out, rx_accept_out, irq_n_out;
    logic [7:0] tx_bytes_sent_in, coll_bytes, busy_n;
    int n_mismatch, num_checks;
    int n_abort = 0;
    // Transmit cases: collisions, byte count, busy cycles, fcs, status.
    logic [3:0] t_n [5] = '{4'h2, 4'h3, 4'h1, 4'h0, 4'h0};
    logic [7:0] t_b [5] = '{8'h05, 8'h05, 8'h0d, 8'h00, 8'h00};
    logic [7:0] t_w [5] = '{8'h03, 8'h00, 8'h00, 8'h1e, 8'h00};
    logic t_f [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [15:0] t_e [5] = '{16'h0092, 16'h0203, 16'h0401, 16'h0100, 16'h0000};

    ecsr_regs #(.LONG_WAIT_LIMIT(20)) u_dut (.*);
    ecsr_core_model u_core (.clk_in(clk_sys_in), .reset_n_in(reset_n_in),
        .dma_start_in(dma_start_out), .tx_start_in(tx_start_out),
        .tx_abort_in(tx_abort_out), .sum_val_in(sum_val), .coll_n_in(coll_n),
        .coll_bytes_in(coll_bytes), .busy_n_in(busy_n), .fcs_bad_in(fcs_bad),
        .dma_done_out(dma_done_in), .dma_sum_out(dma_sum_in),
        .tx_done_out(tx_done_in), .tx_collision_out(tx_collision_in),
        .tx_bytes_out(tx_bytes_sent_in), .tx_busy_out(tx_medium_busy_in),
        .tx_fcs_bad_out(tx_fcs_bad_in));

    // Counts abort pulses sent to the transmit engine.
    always @(posedge clk_sys_in) begin
        if (tx_abort_out === 1'b1) begin
            n_abort <= n_abort + 1;
        end
    end

    // A 20 ns clock.
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task check(input string name, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task bus_rd(input logic [3:0] a);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 rd_val = rdata_out;
    endtask

    task rd_chk(input string name, input logic [3:0] a, input logic [15:0] e);
        bus_rd(a);
        check(name, rd_val, e);
    endtask

    // Polls a self-clearing control bit with a bounded count.
    task wait_clear(input int b);
        for (int i = 0; i < 100; i++) begin
            bus_rd(ecsr_pkg::ADDR_MAIN_CONTROL);
            if (rd_val[b] === 1'b0) return;
        end
        n_mismatch++;
        $display("MISMATCH control bit %0d expected 0 seen 1", b);
        finish_test();
    endtask

    initial begin
        {reset_n_in, wr_in, rd_in, rx_active_in, rx_stored_in} = '0;
        {pause_idle_in, clocks_stable_in, phy_full_duplex_in} = '0;
        {phy_link_up_in, fcs_bad} = '0;
        {addr_in, coll_n, coll_bytes, busy_n} = '0;
        {wdata_in, sum_val} = '0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        // Only the status word is touched before the clocks settle.
        rd_chk("status", ecsr_pkg::ADDR_DEV_STATUS, 16'h0000);
        clocks_stable_in <= 1'b1;
        rd_chk("control", ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0000);
        rd_chk("tx status", ecsr_pkg::ADDR_TX_STATUS, 16'h0000);
        bus_wr(4'hf, 16'hffff);
        rd_chk("unmapped", 4'hf, 16'h0000);
        bus_wr(ecsr_pkg::ADDR_SCRATCH, 16'h5a5a);
        rd_chk("scratch", ecsr_pkg::ADDR_SCRATCH, 16'h5a5a);
        $display("test reset done");
        {pause_idle_in, rx_active_in, phy_full_duplex_in, phy_link_up_in} <= '1;
        rd_chk("levels", ecsr_pkg::ADDR_DEV_STATUS, 16'h7500);
        {rx_active_in, phy_full_duplex_in} <= '0;
        rd_chk("levels", ecsr_pkg::ADDR_DEV_STATUS, 16'h5100);
        $display("test status done");
        bus_wr(ecsr_pkg::ADDR_CHECKSUM, 16'h1234);
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h001d);
        rd_chk("control", ecsr_pkg::ADDR_MAIN_CONTROL, 16'h001d);
        check("copy", {15'h0, dma_copy_out}, 16'h0001);
        check("seed", dma_seed_out, 16'hedcb);
        check("sum en", {15'h0, dma_sum_en_out}, 16'h0000);
        check("rx accept", {15'h0, rx_accept_out}, 16'h0001);
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0000);
        bus_rd(ecsr_pkg::ADDR_MAIN_CONTROL);
        check("copy", {15'h0, dma_copy_out}, 16'h0000);
        check("seed", dma_seed_out, 16'h0000);
        check("sum en", {15'h0, dma_sum_en_out}, 16'h0001);
        check("rx accept", {15'h0, rx_accept_out}, 16'h0000);
        $display("test control done");
        sum_val = 16'hbeef;
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0020);
        bus_rd(ecsr_pkg::ADDR_MAIN_CONTROL);
        check("dma busy", rd_val, 16'h0020);
        wait_clear(ecsr_pkg::BIT_DMA_GO);
        rd_chk("checksum", ecsr_pkg::ADDR_CHECKSUM, 16'hbeef);
        sum_val = 16'h5555;
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0024);
        wait_clear(ecsr_pkg::BIT_DMA_GO);
        rd_chk("checksum", ecsr_pkg::ADDR_CHECKSUM, 16'hbeef);
        $display("test dma done");
        // Window 4 bytes, limit 2; half duplex throughout.
        bus_wr(ecsr_pkg::ADDR_COLL_SETTINGS, 16'h0402);
        for (int k = 0; k < 5; k++) begin
            {coll_n, coll_bytes, busy_n, fcs_bad} = {t_n[k], t_b[k], t_w[k], t_f[k]};
            bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0002);
            bus_rd(ecsr_pkg::ADDR_MAIN_CONTROL);
            check("tx busy", rd_val, 16'h0002);
            wait_clear(ecsr_pkg::BIT_TX_REQ);
            rd_chk("tx status", ecsr_pkg::ADDR_TX_STATUS, t_e[k]);
        end
        check("aborts", 16'(n_abort), 16'h0003);
        $display("test transmit done");
        // Stored packets only count while receive is enabled.
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0001);
        repeat (3) begin
            @(posedge clk_sys_in);
            rx_stored_in <= 1'b1;
            @(posedge clk_sys_in);
            rx_stored_in <= 1'b0;
        end
        rd_chk("count", ecsr_pkg::ADDR_DEV_STATUS, 16'h5103);
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0100);
        bus_wr(ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0100);
        rd_chk("control", ecsr_pkg::ADDR_MAIN_CONTROL, 16'h0000);
        rd_chk("count", ecsr_pkg::ADDR_DEV_STATUS, 16'h5101);
        $display("test packet count done");
        // No flag has a source here, so nothing may be pending.
        bus_wr(ecsr_pkg::ADDR_IRQ_ENABLE, 16'h8001);
        bus_wr(ecsr_pkg::ADDR_IRQ_FLAGS, 16'h0001);
        rd_chk("pending", ecsr_pkg::ADDR_DEV_STATUS, 16'h5101);
        check("irq pin", {15'h0, irq_n_out}, 16'h0001);
        $display("test interrupt done");
        finish_test();
    end
endmodule
